// ==== design/eif_pkg.sv ====
/*
  Constants and carrier types for the external interrupt filter, mask and
  pending block. Assumes a 32-bit register port addressed by byte address.
*/
package eif_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_TRIG_UPPER  = 32'h5600_0090;
  localparam logic [31:0] ADDR_FLT_RSVD_A  = 32'h5600_0094;
  localparam logic [31:0] ADDR_FLT_RSVD_B  = 32'h5600_0098;
  localparam logic [31:0] ADDR_FLT_LOWER   = 32'h5600_009c;
  localparam logic [31:0] ADDR_FLT_UPPER   = 32'h4c60_00a0;
  localparam logic [31:0] ADDR_MASK        = 32'h5600_00a4;
  localparam logic [31:0] ADDR_PEND        = 32'h5600_00a8;

  // Reset values
  localparam logic [31:0] RST_TRIG         = 32'h0000_0000;
  localparam logic [31:0] RST_FLT          = 32'h0000_0000;
  localparam logic [31:0] RST_MASK         = 32'h000f_fff0;
  localparam logic [31:0] RST_PEND         = 32'h0000_0000;
  // Idle pin level; filtered and previous levels reset to it
  localparam logic        PIN_IDLE         = 1'b1;

  // Implemented bits of mask and pending: lines 4 to 23
  localparam logic [31:0] LINE_BITS        = 32'h00ff_fff0;

  // Line counts and field layout
  localparam int          N_UP             = 8;
  localparam int          N_LO             = 12;
  localparam int          FIRST_UP         = 16;
  localparam int          FIRST_LO         = 4;
  localparam int          TRIG_STRIDE      = 4;
  localparam int          TRIG_W           = 3;
  localparam int          FEN_POS          = 3;
  localparam int          FLT_STRIDE       = 8;
  localparam int          FW_W             = 7;
  localparam int          FSEL_POS         = 7;

  // Trigger code classes (upper two bits decide edges)
  localparam logic [2:0]  TRIG_LOW         = 3'h0;
  localparam logic [2:0]  TRIG_HIGH        = 3'h1;
  localparam logic [1:0]  TRIG_FALL        = 2'h1;
  localparam logic [1:0]  TRIG_RISE        = 2'h2;
  localparam logic [1:0]  TRIG_BOTH        = 2'h3;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } eif_bus_req_t;

endpackage : eif_pkg

// ==== design/eif_ext_irq.sv ====
/*
  External interrupt lines 4 to 23: trigger decode and digital noise filter
  for lines 16 to 23, mask and write-1-to-clear pending for lines 4 to 23,
  and one combined interrupt output.
  Assumes all inputs synchronous to core_clk; lines 4 to 15 arrive as
  already-decoded request levels from the lower trigger logic.
  Pins of lines 16 to 23 are taken to idle high, so the filtered level
  starts there and reset alone never looks like a request.
*/
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module eif_ext_irq (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire eif_pkg::eif_bus_req_t bus_req,
  output logic [31:0]               bus_rdata,
  input  wire logic [7:0]           ext_irq_pin,
  input  wire logic [11:0]          ext_irq_req_lo,
  input  wire logic                 filter_alt_clk,
  output logic                      irq_out
);

  logic [31:0] trig_reg;
  logic [31:0] trig_next;
  logic [31:0] flt_lo_reg;
  logic [31:0] flt_lo_next;
  logic [31:0] flt_hi_reg;
  logic [31:0] flt_hi_next;
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic [31:0] pend_reg;
  logic [31:0] pend_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        irq_reg;
  logic        irq_next;
  logic        alt_d_reg;
  logic        alt_tick;
  logic [63:0] flt_all;
  logic [7:0]  req_hi;
  logic [31:0] req_vec;

  assign flt_all  = {flt_hi_reg, flt_lo_reg};
  assign alt_tick = filter_alt_clk & ~alt_d_reg;

  // Per-line filter and trigger decode for lines 16 to 23
  for (genvar i = 0; i < eif_pkg::N_UP; i++) begin : g_line
    logic [2:0] code;
    logic       fen;
    logic       fsel;
    logic [6:0] fwidth;
    logic       tick;
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic       lvl_reg;
    logic       lvl_next;
    logic       prev_reg;
    logic       prev_next;
    logic       hit;

    assign code   = trig_reg[i*eif_pkg::TRIG_STRIDE +: eif_pkg::TRIG_W];
    assign fen    = trig_reg[i*eif_pkg::TRIG_STRIDE + eif_pkg::FEN_POS];
    assign fwidth = flt_all[i*eif_pkg::FLT_STRIDE +: eif_pkg::FW_W];
    assign fsel   = flt_all[i*eif_pkg::FLT_STRIDE + eif_pkg::FSEL_POS];
    assign tick   = fsel ? alt_tick : 1'b1;

    always_comb begin
      cnt_next  = cnt_reg;
      lvl_next  = lvl_reg;
      prev_next = lvl_reg;
      if (ext_irq_pin[i] == lvl_reg) begin
        cnt_next = 7'h00;
      end else if (!fen) begin
        lvl_next = ext_irq_pin[i];
        cnt_next = 7'h00;
      end else if (tick) begin
        if (cnt_reg + 7'h01 >= fwidth) begin
          lvl_next = ext_irq_pin[i];
          cnt_next = 7'h00;
        end else begin
          cnt_next = cnt_reg + 7'h01;
        end
      end
    end

    always_comb begin
      hit = 1'b0;
      if (code == eif_pkg::TRIG_LOW) begin
        hit = ~lvl_reg;
      end else if (code == eif_pkg::TRIG_HIGH) begin
        hit = lvl_reg;
      end else if (code[2:1] == eif_pkg::TRIG_FALL) begin
        hit = prev_reg & ~lvl_reg;
      end else if (code[2:1] == eif_pkg::TRIG_RISE) begin
        hit = ~prev_reg & lvl_reg;
      end else begin
        hit = prev_reg ^ lvl_reg;
      end
    end

    assign req_hi[i] = hit;

    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        // Start at the idle level: no false edge or level hit after reset
        cnt_reg  <= 7'h00;
        lvl_reg  <= eif_pkg::PIN_IDLE;
        prev_reg <= eif_pkg::PIN_IDLE;
      end else begin
        cnt_reg  <= cnt_next;
        lvl_reg  <= lvl_next;
        prev_reg <= prev_next;
      end
    end
  end

  assign req_vec = {8'h00, req_hi, ext_irq_req_lo, 4'h0};

  // Register selects from the full byte address; reserved and unmapped
  // words select nothing, so they read zero and ignore writes
  logic sel_trig;
  logic sel_flt_lo;
  logic sel_flt_hi;
  logic sel_mask;
  logic sel_pend;

  always_comb begin
    sel_trig   = 1'b0;
    sel_flt_lo = 1'b0;
    sel_flt_hi = 1'b0;
    sel_mask   = 1'b0;
    sel_pend   = 1'b0;
    if (bus_req.addr == eif_pkg::ADDR_TRIG_UPPER) begin
      sel_trig = 1'b1;
    end else if (bus_req.addr == eif_pkg::ADDR_FLT_LOWER) begin
      sel_flt_lo = 1'b1;
    end else if (bus_req.addr == eif_pkg::ADDR_FLT_UPPER) begin
      sel_flt_hi = 1'b1;
    end else if (bus_req.addr == eif_pkg::ADDR_MASK) begin
      sel_mask = 1'b1;
    end else if (bus_req.addr == eif_pkg::ADDR_PEND) begin
      sel_pend = 1'b1;
    end
  end

  // Trigger codes and filter enables of lines 16 to 23
  always_comb begin
    trig_next = trig_reg;
    if (bus_req.wr && sel_trig) begin
      trig_next = bus_req.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trig_reg <= eif_pkg::RST_TRIG;
    end else begin
      trig_reg <= trig_next;
    end
  end

  // Filter clock selects and widths: low word lines 16 to 19, high 20 to 23
  always_comb begin
    flt_lo_next = flt_lo_reg;
    flt_hi_next = flt_hi_reg;
    if (bus_req.wr && sel_flt_lo) begin
      flt_lo_next = bus_req.wdata;
    end
    if (bus_req.wr && sel_flt_hi) begin
      flt_hi_next = bus_req.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flt_lo_reg <= eif_pkg::RST_FLT;
      flt_hi_reg <= eif_pkg::RST_FLT;
    end else begin
      flt_lo_reg <= flt_lo_next;
      flt_hi_reg <= flt_hi_next;
    end
  end

  // Mask, a one masks; bits outside lines 4 to 23 are held at zero
  always_comb begin
    mask_next = mask_reg;
    if (bus_req.wr && sel_mask) begin
      mask_next = bus_req.wdata & eif_pkg::LINE_BITS;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mask_reg <= eif_pkg::RST_MASK;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // Pending: write one to clear; a request in the same cycle wins
  always_comb begin
    pend_next = pend_reg;
    if (bus_req.wr && sel_pend) begin
      pend_next = pend_reg & ~bus_req.wdata;
    end
    pend_next = pend_next | (req_vec & eif_pkg::LINE_BITS);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pend_reg <= eif_pkg::RST_PEND;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // Read data stands one cycle after the read strobe, zero otherwise
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (bus_req.rd) begin
      if (sel_trig) begin
        rdata_next = trig_reg;
      end else if (sel_flt_lo) begin
        rdata_next = flt_lo_reg;
      end else if (sel_flt_hi) begin
        rdata_next = flt_hi_reg;
      end else if (sel_mask) begin
        rdata_next = mask_reg;
      end else if (sel_pend) begin
        rdata_next = pend_reg;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Combined request from the next pending and mask values, so a clear
  // or a mask write drops it at the very edge that takes the write
  always_comb begin
    irq_next = |(pend_next & ~mask_next & eif_pkg::LINE_BITS);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // Last sample of the alternate filter clock; idles low like the clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alt_d_reg <= 1'b0;
    end else begin
      alt_d_reg <= filter_alt_clk;
    end
  end

  assign bus_rdata = rdata_reg;
  assign irq_out   = irq_reg;

endmodule : eif_ext_irq

// ==== verif/eif_ext_irq_properties.sv ====
/* Port checker for eif_ext_irq.
   Assumes one clock domain; bound to every instance below. */
`timescale 1ns/100ps
module eif_ext_irq_properties (
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire eif_pkg::eif_bus_req_t bus_req,
  input wire logic [31:0]           bus_rdata,
  input wire logic [7:0]            ext_irq_pin,
  input wire logic [11:0]           ext_irq_req_lo,
  input wire logic                  filter_alt_clk,
  input wire logic                  irq_out
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  a_reset_quiet: assert property ($fell(sys_rst) |-> !irq_out && bus_rdata == 32'h0)
    else $error("outputs busy after reset");
  a_mask_reset: assert property ($fell(sys_rst) ##1 (bus_req.rd &&
    bus_req.addr == eif_pkg::ADDR_MASK) |=> bus_rdata == eif_pkg::RST_MASK)
    else $error("mask reset value wrong");
  a_rsvd_zero: assert property (bus_req.rd && (bus_req.addr == eif_pkg::ADDR_FLT_RSVD_A ||
    bus_req.addr == eif_pkg::ADDR_FLT_RSVD_B) |=> bus_rdata == 32'h0)
    else $error("reserved word not zero");
  a_unused_bits: assert property (bus_req.rd && (bus_req.addr == eif_pkg::ADDR_MASK ||
    bus_req.addr == eif_pkg::ADDR_PEND) |=> bus_rdata[3:0] == 4'h0 && bus_rdata[31:24] == 8'h0)
    else $error("unused bits set");
  a_mask_readback: assert property ((bus_req.wr && bus_req.addr == eif_pkg::ADDR_MASK) ##1
    (bus_req.rd && bus_req.addr == eif_pkg::ADDR_MASK)
    |=> bus_rdata == ($past(bus_req.wdata, 2) & eif_pkg::LINE_BITS))
    else $error("mask readback wrong");
  a_filt_readback: assert property ((bus_req.wr && bus_req.addr == eif_pkg::ADDR_FLT_LOWER) ##1
    (bus_req.rd && bus_req.addr == eif_pkg::ADDR_FLT_LOWER) |=> bus_rdata == $past(bus_req.wdata, 2))
    else $error("filter readback wrong");
  a_pend_sets: assert property (bus_req.rd && bus_req.addr == eif_pkg::ADDR_PEND &&
    !$past(sys_rst) |=> (bus_rdata[15:4] & $past(ext_irq_req_lo, 2)) == $past(ext_irq_req_lo, 2))
    else $error("request not pending");
  a_mask_quiets: assert property (bus_req.wr && bus_req.addr == eif_pkg::ADDR_MASK &&
    bus_req.wdata[23:4] == 20'hfffff |=> !irq_out)
    else $error("irq while all masked");
endmodule : eif_ext_irq_properties

bind eif_ext_irq eif_ext_irq_properties u_props (.core_clk(core_clk), .sys_rst(sys_rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .ext_irq_pin(ext_irq_pin),
  .ext_irq_req_lo(ext_irq_req_lo), .filter_alt_clk(filter_alt_clk), .irq_out(irq_out));

// ==== verif/eif_pin_drv.sv ====
/* Off-chip sources on lines 16 to 23 and the alternate filter clock.
   Assumes it runs from the core clock. */
`timescale 1ns/100ps
module eif_pin_drv (
  input  wire logic       core_clk,
  input  wire logic [7:0] want,
  input  wire logic [1:0] lag,
  input  wire logic       alt_run,
  output logic [7:0]      pins,
  output logic            alt_clk
);
  logic [1:0] wait_reg = 2'h0;
  logic [1:0] div_reg  = 2'h0;
  initial pins = 8'hff;
  // New level reaches the pins lag cycles late; alternate clock idles low
  always @(posedge core_clk) begin
    wait_reg <= (pins == want) ? 2'h0 : wait_reg + 2'h1;
    if (pins != want && wait_reg >= lag) pins <= want;
    div_reg <= alt_run ? div_reg + 2'h1 : 2'h0;
  end
  assign alt_clk = div_reg[1];
endmodule : eif_pin_drv

// ==== verif/eif_ext_irq_tb.sv ====
/* Self-checking bench for eif_ext_irq.
   Assumes the pin model eif_pin_drv and the bound port checker. */
`timescale 1ns/100ps
module eif_ext_irq_tb;
  logic                  core_clk = 1'b0;
  logic                  sys_rst  = 1'b1;
  eif_pkg::eif_bus_req_t req      = '0;
  logic [31:0]           rdata, q, r, c;
  logic [7:0]            want     = 8'hff;
  logic [7:0]            pins;
  logic [11:0]           req_lo   = 12'h0;
  logic [1:0]            lag      = 2'h0;
  logic                  alt_run  = 1'b0;
  logic                  alt_clk, irq;
  integer                seed = 32'hae2000a7, n_errors = 0, n_checks = 0;
  int                    len_t [4] = '{3, 8, 6, 20};
  logic [31:0]           adr [8] = '{eif_pkg::ADDR_MASK, eif_pkg::ADDR_PEND,
    eif_pkg::ADDR_TRIG_UPPER, eif_pkg::ADDR_FLT_LOWER, eif_pkg::ADDR_FLT_UPPER,
    eif_pkg::ADDR_FLT_RSVD_A, eif_pkg::ADDR_FLT_RSVD_B, 32'h5600_00b0};
  eif_ext_irq uut (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(req), .bus_rdata(rdata),
    .ext_irq_pin(pins), .ext_irq_req_lo(req_lo), .filter_alt_clk(alt_clk), .irq_out(irq));
  eif_pin_drv pin_model (.core_clk(core_clk), .want(want), .lag(lag), .alt_run(alt_run),
    .pins(pins), .alt_clk(alt_clk));
  always #5 core_clk = ~core_clk;
  function automatic logic f_edge(input logic [2:0] k, input logic fall);
    return fall ? (k[2:1] != 2'h2) : (k[2:1] != 2'h1);
  endfunction : f_edge
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, d);
    @(posedge core_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) req <= '0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge core_clk) req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk) req <= '0;
    #1 d = rdata;
  endtask : rd
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    #200000 n_errors++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(adr[i], q);
      chk("reset value", i == 0 ? eif_pkg::RST_MASK : 32'h0, q);
    end
    for (int i = 0; i < 8; i++) begin
      if (i == 1) continue;
      r = $random(seed);
      @(posedge core_clk) req <= '{adr[i], r, 1'b1, 1'b0};
      rd(adr[i], q);
      chk("readback", i == 0 ? r & eif_pkg::LINE_BITS : (i < 5 ? r : 32'h0), q);
    end
    $display("registers done");
    for (int k = 0; k < 8; k++) begin
      lag <= 2'($random(seed));
      wr(eif_pkg::ADDR_TRIG_UPPER, 32'(k));
      for (int p = 0; p < 2; p++) begin
        wr(eif_pkg::ADDR_PEND, eif_pkg::LINE_BITS);
        want[0] <= 1'(p);
        repeat (8) @(posedge core_clk);
        rd(eif_pkg::ADDR_PEND, q);
        chk("trigger code", 32'(f_edge(3'(k), p == 0)), 32'(q[16]));
      end
    end
    $display("trigger codes done");
    lag <= 2'h0;
    wr(eif_pkg::ADDR_TRIG_UPPER, 32'h80);
    for (int k = 0; k < 4; k++) begin
      alt_run <= k[1];
      wr(eif_pkg::ADDR_FLT_LOWER, {16'h0, k[1], 7'(k[1] ? 3 : 5), 8'h0});
      wr(eif_pkg::ADDR_PEND, eif_pkg::LINE_BITS);
      want[1] <= 1'b0;
      repeat (len_t[k]) @(posedge core_clk);
      want[1] <= 1'b1;
      repeat (24) @(posedge core_clk);
      rd(eif_pkg::ADDR_PEND, q);
      chk("filter", 32'((k[1] ? len_t[k] / 4 : len_t[k]) >= (k[1] ? 3 : 5)), 32'(q[17]));
    end
    $display("filter done");
    alt_run <= 1'b0;
    wr(eif_pkg::ADDR_PEND, eif_pkg::LINE_BITS);
    wr(eif_pkg::ADDR_MASK, 32'h0);
    r = {16'h0, 12'($random(seed)) | 12'h1, 4'h0};
    req_lo <= r[15:4];
    rd(eif_pkg::ADDR_PEND, q);
    req_lo <= 12'h0;
    chk("pending", r, q);
    chk("irq raised", 32'h1, 32'(irq));
    c = $random(seed) & eif_pkg::LINE_BITS & ~32'h10;
    wr(eif_pkg::ADDR_PEND, c);
    rd(eif_pkg::ADDR_PEND, q);
    chk("partial clear", r & ~c, q);
    wr(eif_pkg::ADDR_MASK, eif_pkg::LINE_BITS);
    #1 chk("irq masked", 32'h0, 32'(irq));
    wr(eif_pkg::ADDR_PEND, eif_pkg::LINE_BITS);
    rd(eif_pkg::ADDR_PEND, q);
    chk("full clear", 32'h0, q);
    $display("interrupt done");
    summarize();
  end
endmodule : eif_ext_irq_tb
